// ---- src/lbd_hbd_if.sv ----
// Carrier between the control top and the higher-bias timer
`timescale 1ns/10ps
`default_nettype none
interface lbd_hbd_if;
	logic       lcd_tick;
	logic [2:0] prescale;
	logic       transition;
	logic [2:0] duration;
	logic       high_bias;
	modport ctrl (output lcd_tick, output prescale, output transition,
		output duration, input high_bias);
	modport timer (input lcd_tick, input prescale, input transition,
		input duration, output high_bias);
endinterface : lbd_hbd_if
`default_nettype wire

// ---- src/lbd_hbd_timer.sv ----
// Higher-bias drive timer on clk_in, counting down on the prescaler output
`timescale 1ns/10ps
`default_nettype none
module lbd_hbd_timer
	import lbd_pkg::*;
(
	input  wire logic  clk_in,
	input  wire logic  rst_b_in,
	lbd_hbd_if.timer   hbd
);
	logic [4:0] presc_cnt_q;
	logic [4:0] presc_mask;
	logic [2:0] presc_code;
	logic       presc_tick;
	logic [2:0] left_q;
	logic [2:0] left_d;
	logic       high_q;

	////////////////////////////////////////////////////////////////////////
	// Reserved prescale codes fall back to the largest divider
	assign presc_code = (hbd.prescale > LBD_PRESC_MAX) ? LBD_PRESC_MAX
		: hbd.prescale;
	assign presc_mask = 5'((6'h01 << presc_code) - 6'h01);
	assign presc_tick = hbd.lcd_tick
		&& ((presc_cnt_q & presc_mask) == presc_mask);

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			presc_cnt_q <= 5'h00;
		else if (hbd.lcd_tick)
			presc_cnt_q <= presc_cnt_q + 5'h01;
	end

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		left_d = left_q;
		if (hbd.transition)
			left_d = hbd.duration;
		else if (presc_tick && left_q != 3'h0)
			left_d = left_q - 3'h1;
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			left_q <= 3'h0;
			high_q <= 1'b0;
		end
		else
		begin
			left_q <= left_d;
			if (hbd.duration == LBD_DUR_CONT)
				high_q <= 1'b1;
			else if (hbd.duration == LBD_DUR_OFF)
				high_q <= 1'b0;
			else
				high_q <= (left_d != 3'h0);
		end
	end

	assign hbd.high_bias = high_q;
endmodule : lbd_hbd_timer
`default_nettype wire

// ---- src/lbd_pkg.sv ----
// Constants and field layout of the LCD bias and pump control block
package lbd_pkg;
	localparam int          LBD_DATA_W      = 32;
	localparam int          LBD_ADDR_W      = 16;
	localparam int          LBD_REG_W       = 8;
	// Register indices; byte address is four times the index
	localparam logic [11:0] LBD_CTRL_IDX    = 12'hFB5;
	localparam logic [11:0] LBD_STAT_IDX    = 12'hFBF;
	localparam logic [15:0] LBD_CTRL_ADDR   = {2'h0, LBD_CTRL_IDX, 2'h0};
	localparam logic [15:0] LBD_STAT_ADDR   = {2'h0, LBD_STAT_IDX, 2'h0};
	localparam logic [7:0]  LBD_CTRL_RESET  = 8'h00;
	// Field positions of the control register
	localparam int          LBD_DUR_MSB     = 7;
	localparam int          LBD_DUR_LSB     = 5;
	localparam int          LBD_PUMP_BIT    = 4;
	localparam int          LBD_BGSEL_BIT   = 3;
	localparam int          LBD_CON_MSB     = 2;
	localparam int          LBD_CON_LSB     = 0;
	// Field positions of the status register
	localparam int          LBD_ST_PEND_BIT = 8;
	localparam int          LBD_ST_DEAD_BIT = 9;
	localparam int          LBD_ST_HIGH_BIT = 10;
	// Operating mode bit that selects type A waveforms
	localparam int          LBD_MODE_TYPE_A = 2;
	// Duration codes
	localparam logic [2:0]  LBD_DUR_OFF     = 3'h0;
	localparam logic [2:0]  LBD_DUR_CONT    = 3'h7;
	// Largest legal prescale code
	localparam logic [2:0]  LBD_PRESC_MAX   = 3'h5;
	localparam int          LBD_DEAD_W      = 4;
	localparam logic [3:0]  LBD_DEAD_ZERO   = 4'h0;
endpackage : lbd_pkg

// ---- src/lbd_top.sv ----
// LCD bias drive and charge pump control register with APB access
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module lbd_top
	import lbd_pkg::*;
(
	input  wire logic                            clk_in,
	input  wire logic                            rst_b_in,
	input  wire logic                            psel_in,
	input  wire logic                            penable_in,
	input  wire logic                            pwrite_in,
	input  wire logic [lbd_pkg::LBD_ADDR_W-1:0]  paddr_in,
	input  wire logic [lbd_pkg::LBD_DATA_W-1:0]  pwdata_in,
	output logic      [lbd_pkg::LBD_DATA_W-1:0]  prdata_out,
	output logic                                 pready_out,
	output logic                                 pslverr_out,
	input  wire logic                            lcd_clk_tick_in,
	input  wire logic [2:0]                      prescale_code_in,
	input  wire logic [3:0]                      lcd_operating_mode_in,
	input  wire logic                            third_duty_in,
	input  wire logic                            wave_transition_in,
	input  wire logic                            wave_end_in,
	input  wire logic                            frame_tick_in,
	output logic                                 high_bias_sel_out,
	output logic                                 bias_generator_select_out,
	output logic                                 pump_enable_out,
	output logic      [2:0]                      pump_level_out,
	output logic                                 outputs_grounded_out
);
	logic                    rst_meta_q;
	logic                    rst_sync_q;
	logic [LBD_REG_W-1:0]    shadow_q;
	logic [LBD_REG_W-1:0]    applied_q;
	logic [LBD_REG_W-1:0]    next_cfg;
	logic                    pending_q;
	logic                    ready_q;
	logic                    slverr_q;
	logic [LBD_DATA_W-1:0]   rdata_q;
	logic                    setup_phase;
	logic                    write_done;
	logic                    hit_ctrl;
	logic                    hit_stat;
	logic [LBD_DEAD_W-1:0]   dead_cnt_q;
	logic [LBD_DEAD_W-1:0]   dead_cnt_d;
	logic                    grounded_q;
	logic                    bgsel_q;
	logic                    pump_q;
	logic [2:0]              level_q;
	logic                    type_a;
	logic                    ctrl_write;
	logic                    bad_access;
	logic                    pump_next;
	logic [2:0]              contrast_next;
	logic [LBD_DATA_W-1:0]   stat_word;
	lbd_hbd_if               hbd ();

	////////////////////////////////////////////////////////////////////////
	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Dead frame count from contrast code, waveform type and duty
	function automatic logic [LBD_DEAD_W-1:0] dead_count
	(
		input logic [2:0] code,
		input logic       is_type_a,
		input logic       third
	);
		logic [LBD_DEAD_W-1:0] n;
		n = LBD_DEAD_ZERO;
		unique case (code)
			3'h0: n = 4'h0;
			3'h1: n = 4'h1;
			3'h2: n = 4'h2;
			3'h3: n = 4'h0;
			3'h4: n = 4'h4;
			3'h5: n = is_type_a ? 4'h5 : 4'h6;
			3'h6:
			begin
				if (is_type_a)
					n = 4'h6;
				else
					n = third ? 4'h0 : 4'h8;
			end
			3'h7:
			begin
				if (is_type_a)
					n = third ? 4'h0 : 4'h8;
				else
					n = 4'h0;
			end
		endcase
		return n;
	endfunction : dead_count

	////////////////////////////////////////////////////////////////////////
	// APB slave: no wait states, registered answer
	assign setup_phase = psel_in && !penable_in;
	assign write_done  = psel_in && penable_in && ready_q && pwrite_in
		&& !slverr_q;
	assign hit_ctrl    = (paddr_in == LBD_CTRL_ADDR);
	assign hit_stat    = (paddr_in == LBD_STAT_ADDR);
	assign ctrl_write  = write_done && hit_ctrl;
	// Status is read only; any other offset is refused as well
	assign bad_access  = !(hit_ctrl || (hit_stat && !pwrite_in));

	// No wait states: the answer always follows the setup edge by one
	always_ff @(posedge clk_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			ready_q <= 1'b0;
		else
			ready_q <= setup_phase;
	end

	always_ff @(posedge clk_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			slverr_q <= 1'b0;
		else if (setup_phase)
			slverr_q <= bad_access;
		else if (ready_q)
			slverr_q <= 1'b0;
	end

	// Status word; bits above the flags read as zero
	always_comb
	begin
		stat_word                  = 32'h0000_0000;
		stat_word[LBD_REG_W-1:0]   = applied_q;
		stat_word[LBD_ST_PEND_BIT] = pending_q;
		stat_word[LBD_ST_DEAD_BIT] = grounded_q;
		stat_word[LBD_ST_HIGH_BIT] = hbd.high_bias;
	end

	always_ff @(posedge clk_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			rdata_q <= 32'h0000_0000;
		else if (setup_phase && !pwrite_in)
		begin
			rdata_q <= 32'h0000_0000;
			if (hit_ctrl)
				rdata_q[LBD_REG_W-1:0] <= shadow_q;
			else if (hit_stat)
				rdata_q <= stat_word;
		end
		else if (ready_q)
			rdata_q <= 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////
	// Shadow copy written by software
	always_ff @(posedge clk_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			shadow_q <= LBD_CTRL_RESET;
		else if (ctrl_write)
			shadow_q <= pwdata_in[LBD_REG_W-1:0];
	end

	// Write in the same cycle as the waveform end stays pending
	always_ff @(posedge clk_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			pending_q <= 1'b0;
		else if (ctrl_write)
			pending_q <= 1'b1;
		else if (wave_end_in)
			pending_q <= 1'b0;
	end

	assign next_cfg = (wave_end_in && pending_q) ? shadow_q : applied_q;
	assign pump_next     = next_cfg[LBD_PUMP_BIT];
	assign contrast_next = next_cfg[LBD_CON_MSB:LBD_CON_LSB];

	always_ff @(posedge clk_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			applied_q <= LBD_CTRL_RESET;
		else
			applied_q <= next_cfg;
	end

	////////////////////////////////////////////////////////////////////////
	// Bias generator, pump enable and pump level
	always_ff @(posedge clk_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			bgsel_q <= 1'b0;
		else
			bgsel_q <= next_cfg[LBD_BGSEL_BIT];
	end

	// No stop-mode gating: the pump keeps running once enabled
	always_ff @(posedge clk_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			pump_q <= 1'b0;
		else
			pump_q <= pump_next;
	end

	// Zero with the pump off, so a stale code never reaches the pump
	always_ff @(posedge clk_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			level_q <= 3'h0;
		else if (pump_next)
			level_q <= contrast_next;
		else
			level_q <= 3'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// Dead frame cycles after each waveform, pump off only
	assign type_a = lcd_operating_mode_in[LBD_MODE_TYPE_A];

	always_comb
	begin
		dead_cnt_d = dead_cnt_q;
		if (wave_end_in)
		begin
			if (pump_next)
				dead_cnt_d = LBD_DEAD_ZERO;
			else
				dead_cnt_d = dead_count(contrast_next, type_a,
					third_duty_in);
		end
		else if (frame_tick_in && dead_cnt_q != LBD_DEAD_ZERO)
			dead_cnt_d = dead_cnt_q - 4'h1;
	end

	always_ff @(posedge clk_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			dead_cnt_q <= LBD_DEAD_ZERO;
		else
			dead_cnt_q <= dead_cnt_d;
	end

	// Own flop so the grounding output never glitches on the decode
	always_ff @(posedge clk_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			grounded_q <= 1'b0;
		else
			grounded_q <= (dead_cnt_d != LBD_DEAD_ZERO);
	end

	////////////////////////////////////////////////////////////////////////
	// Higher-bias timer runs on the applied duration
	// A pending write never reloads a pulse under way; once applied, duration OFF or CONT overrides it
	assign hbd.lcd_tick   = lcd_clk_tick_in;
	assign hbd.prescale   = prescale_code_in;
	assign hbd.transition = wave_transition_in;
	assign hbd.duration   = applied_q[LBD_DUR_MSB:LBD_DUR_LSB];

	lbd_hbd_timer u_timer
	(
		.clk_in   (clk_in),
		.rst_b_in (rst_sync_q),
		.hbd      (hbd)
	);

	////////////////////////////////////////////////////////////////////////
	assign prdata_out                = rdata_q;
	assign pready_out                = ready_q;
	assign pslverr_out               = slverr_q;
	assign high_bias_sel_out         = hbd.high_bias;
	assign bias_generator_select_out = bgsel_q;
	assign pump_enable_out           = pump_q;
	assign pump_level_out            = level_q;
	assign outputs_grounded_out      = grounded_q;
endmodule : lbd_top
`default_nettype wire

// ---- tb/lbd_assertions.sv ----
// Port checker for the bias and pump control block
`timescale 1ns/10ps
`default_nettype none
module lbd_assertions
	import lbd_pkg::*;
(
	input  wire logic                           clk_in,
	input  wire logic                           rst_b_in,
	input  wire logic                           psel_in,
	input  wire logic                           penable_in,
	input  wire logic                           pwrite_in,
	input  wire logic [lbd_pkg::LBD_ADDR_W-1:0] paddr_in,
	input  wire logic                           pready_out,
	input  wire logic                           pslverr_out,
	input  wire logic                           wave_transition_in,
	input  wire logic                           wave_end_in,
	input  wire logic                           frame_tick_in,
	input  wire logic                           high_bias_sel_out,
	input  wire logic                           bias_generator_select_out,
	input  wire logic                           pump_enable_out,
	input  wire logic [2:0]                     pump_level_out,
	input  wire logic                           outputs_grounded_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	////////////////////////////////////////////////////////////////////////
	property p_ready;
		psel_in && !penable_in |=> pready_out;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	property p_err;
		pready_out |-> pslverr_out == !(paddr_in == LBD_CTRL_ADDR ||
			(paddr_in == LBD_STAT_ADDR && !pwrite_in));
	endproperty
	a_err: assert property (p_err) else $error("wrong error response");
	property p_pump_chg;
		$changed(pump_enable_out) |-> $past(wave_end_in);
	endproperty
	a_pump_chg: assert property (p_pump_chg)
		else $error("pump moved");
	property p_bias_chg;
		$changed(bias_generator_select_out) |-> $past(wave_end_in);
	endproperty
	a_bias_chg: assert property (p_bias_chg)
		else $error("bias moved");
	property p_level;
		!pump_enable_out |-> pump_level_out == 3'h0;
	endproperty
	a_level: assert property (p_level)
		else $error("level with pump off");
	property p_nodead;
		pump_enable_out ##1 pump_enable_out |-> !outputs_grounded_out;
	endproperty
	a_nodead: assert property (p_nodead)
		else $error("dead with pump on");
	property p_gnd_fall;
		$fell(outputs_grounded_out) |-> frame_tick_in || wave_end_in ||
			$past(frame_tick_in) || $past(wave_end_in);
	endproperty
	a_gnd_fall: assert property (p_gnd_fall)
		else $error("bad ground end");
	property p_hb_rise;
		$rose(high_bias_sel_out) |-> $past(wave_transition_in || wave_end_in)
			|| $past(wave_end_in, 2);
	endproperty
	a_hb_rise: assert property (p_hb_rise)
		else $error("bad bias start");
	c_err: cover property (pready_out && pslverr_out);
	c_gnd: cover property ($rose(outputs_grounded_out));
	c_hb: cover property ($rose(high_bias_sel_out));
endmodule : lbd_assertions
`default_nettype wire

// ---- tb/lbd_panel_model.sv ----
// Glass and frame timing model on the far side of the block
`timescale 1ns/10ps
`default_nettype none
module lbd_panel_model
(
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	input  wire logic       outputs_grounded_in,
	input  wire logic       wave_end_in,
	output logic            lcd_clk_tick_out,
	output logic            frame_tick_out,
	output logic [3:0]      dead_frames_out
);
	logic [1:0] div_q;
	// Selected clock at full rate; prescaler does all the dividing
	assign lcd_clk_tick_out = 1'b1;
	assign frame_tick_out = div_q == 2'h2;
	always_ff @(posedge clk_in or negedge rst_b_in)
		if (!rst_b_in)
			div_q <= 2'h0;
		else
			div_q <= frame_tick_out ? 2'h0 : div_q + 2'h1;
	// Frames seen with all outputs grounded since the last waveform end
	always_ff @(posedge clk_in or negedge rst_b_in)
		if (!rst_b_in)
			dead_frames_out <= 4'h0;
		else if (wave_end_in)
			dead_frames_out <= 4'h0;
		else if (frame_tick_out && outputs_grounded_in)
			dead_frames_out <= dead_frames_out + 4'h1;
endmodule : lbd_panel_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Testbench for the bias and pump control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import lbd_pkg::*;
	logic        clk, rst_b, psel, penable, pwrite, wt, we, pready, perr;
	logic        lt, ft, hb, bg, pe, gnd, third;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [2:0]  presc, lvl;
	logic [3:0]  mode, dead;
	int          bad_count, checked;
	int bc[6] = '{0, 1, 2, 4, 5, 6};
	int bx[6] = '{0, 1, 2, 4, 6, 8};
	int ac[4] = '{0, 1, 2, 7};
	int ax[4] = '{0, 1, 2, 8};
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	lbd_top lbd_top_i (.clk_in(clk), .rst_b_in(rst_b), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(perr), .lcd_clk_tick_in(lt), .prescale_code_in(presc),
		.lcd_operating_mode_in(mode), .third_duty_in(third),
		.wave_transition_in(wt), .wave_end_in(we), .frame_tick_in(ft),
		.high_bias_sel_out(hb), .bias_generator_select_out(bg),
		.pump_enable_out(pe), .pump_level_out(lvl),
		.outputs_grounded_out(gnd));
	lbd_panel_model lbd_panel_model_i (.clk_in(clk), .rst_b_in(rst_b),
		.outputs_grounded_in(gnd), .wave_end_in(we), .lcd_clk_tick_out(lt),
		.frame_tick_out(ft), .dead_frames_out(dead));
	////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("checked %0d bad %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Request held until pready is seen high at a rising edge
	task automatic xfer(input logic w, input logic [15:0] a,
		input logic [31:0] d, input logic [31:0] x, input logic xe);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		if (!w)
			chk(prdata, x);
		chk(32'(perr), 32'(xe));
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic pulse_end;
		@(posedge clk);
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
		@(negedge clk);
	endtask : pulse_end
	task automatic dead_run(input logic [3:0] m, input int c, input int x);
		@(posedge clk);
		mode <= m;
		xfer(1'b1, LBD_CTRL_ADDR, 32'(c), 32'h0, 1'b0);
		pulse_end;
		repeat (40) @(posedge clk);
		chk(32'(dead), 32'(x));
	endtask : dead_run
	task automatic hb_run(input int dr, input int p);
		int n, lo, hi;
		hi = dr == 7 ? 200 : dr << p;
		lo = dr == 7 ? 200 : (dr == 0 ? 0 : ((dr - 1) << p) + 1);
		@(posedge clk);
		presc <= 3'(p);
		xfer(1'b1, LBD_CTRL_ADDR, 32'(dr << 5), 32'h0, 1'b0);
		pulse_end;
		@(posedge clk);
		wt <= 1'b1;
		@(posedge clk);
		wt <= 1'b0;
		n = 0;
		repeat (200)
		begin
			@(negedge clk);
			n += int'(hb === 1'b1);
		end
		chk(32'(n >= lo && n <= hi), 32'h1);
	endtask : hb_run
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{rst_b, psel, penable, pwrite, wt, we, paddr, pwdata} = '0;
		{presc, mode, third, bad_count, checked} = '0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		xfer(1'b0, LBD_CTRL_ADDR, 32'h0, 32'h0, 1'b0);
		xfer(1'b1, LBD_CTRL_ADDR, 32'h1D, 32'h0, 1'b0);
		xfer(1'b0, LBD_CTRL_ADDR, 32'h0, 32'h1D, 1'b0);
		xfer(1'b0, LBD_STAT_ADDR, 32'h0, 32'h100, 1'b0);
		chk(32'(pe), 32'h0);
		pulse_end;
		chk(32'({bg, pe, lvl}), 32'h1D);
		repeat (40) @(posedge clk);
		chk(32'(dead), 32'h0);
		xfer(1'b1, LBD_STAT_ADDR, 32'h0, 32'h0, 1'b1);
		xfer(1'b0, 16'h0000, 32'h0, 32'h0, 1'b1);
		$display("test access done");
		foreach (bc[i]) dead_run(4'h2, bc[i], bx[i]);
		foreach (ac[i]) dead_run(4'h4, ac[i], ax[i]);
		third <= 1'b1;
		dead_run(4'h2, 6, 0);
		dead_run(4'h4, 7, 0);
		third <= 1'b0;
		$display("test contrast done");
		for (int d = 0; d < 8; d++) hb_run(d, 0);
		hb_run(2, 2);
		hb_run(6, 5);
		$display("test bias done");
		stop_test;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		stop_test;
	end
endmodule : testbench
bind lbd_top lbd_assertions lbd_assertions_i (.clk_in(clk_in),
	.rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
	.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pready_out(pready_out),
	.pslverr_out(pslverr_out), .wave_transition_in(wave_transition_in),
	.wave_end_in(wave_end_in), .frame_tick_in(frame_tick_in),
	.high_bias_sel_out(high_bias_sel_out),
	.bias_generator_select_out(bias_generator_select_out),
	.pump_enable_out(pump_enable_out), .pump_level_out(pump_level_out),
	.outputs_grounded_out(outputs_grounded_out));
`default_nettype wire
